// File: dcbq_pkg.sv
// Package for the debug comparator B qualifier block
// Functional notes
// - Bit 7 enables direction in the comparator B match.
// - Full modes use comparator A direction enable and value instead.
// - Bit 6 selects match: 0 write cycles, 1 read cycles.
// - Direction value ignored when direction enable is 0.
// - Full modes ignore bit 6; comparator A value governs.
// - Page bit 1: match only paged access, page:addr[13:0] compared.
// - Page bit 0: match only non-paged access, bit 16 from address.
// - Full modes compare data; page bit and bit 16 ignored.
// - Address bit 16 is compared against register bit 0.
// - Reset clears all bits; qualifying end-trace reset keeps 7,6,5,0.
package dcbq_pkg;

  //--------------------------------------------------------------------------
  // Register map
  //--------------------------------------------------------------------------
  localparam logic [7:0]  CMP_B_EXT_OFFSET = 8'h09; // Register index
  localparam logic [11:0] CMP_B_EXT_ADDR   = 12'h024; // Index times four
  localparam logic [11:0] CMP_A_EXT_ADDR   = 12'h020;
  localparam logic [11:0] CMP_B_ADR_ADDR   = 12'h040;
  localparam logic [11:0] CTRL_ADDR        = 12'h044;
  localparam logic [11:0] STATUS_ADDR      = 12'h048;
  localparam logic [7:0]  EXT_RESET        = 8'h00;
  localparam logic [7:0]  EXT_RD_MASK      = 8'hE1; // Bits 4..1 read zero
  localparam logic [7:0]  EXT_KEEP_MASK    = 8'hE1; // Kept on end-trace
  localparam int          BIT_DIR_EN       = 7;
  localparam int          BIT_DIR_VAL      = 6;
  localparam int          BIT_PAGE         = 5;
  localparam int          BIT_B16          = 0;
  localparam int          CTRL_FULL        = 0;
  localparam int          CTRL_DBG_EN      = 1;
  localparam int          CTRL_BEGIN       = 2;

  // Core bus sample
  typedef struct packed {
    logic        valid;     // Bus cycle active
    logic        read;      // 1 read, 0 write
    logic        paged;     // Paged program access indication
    logic [2:0]  page;      // Page value
    logic [16:0] addr;      // Core address
    logic [7:0]  data;      // Data value
  } dcbq_bus_t;

  // Comparator A qualifier settings
  typedef struct packed {
    logic dir_en;           // Comparator A direction enable
    logic dir_val;          // Comparator A direction value
  } dcbq_cmpa_t;

endpackage

// File: dcbq_top.sv
// Comparator B qualifier with APB register access
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module dcbq_top (
  input  wire logic               clk_sys,   // Bus clock
  input  wire logic               nrst,      // Async reset, low
  input  wire logic               psel,      // APB select
  input  wire logic               penable,   // APB enable
  input  wire logic               pwrite,    // APB direction
  input  wire logic [11:0]        paddr,     // APB byte address
  input  wire logic [31:0]        pwdata,    // APB write data
  output logic      [31:0]        prdata,    // APB read data
  output logic                    pready,    // APB ready
  output logic                    pslverr,   // APB error
  input  wire logic               end_trace_rst, // End-trace reset pulse
  input  wire dcbq_pkg::dcbq_bus_t core_bus, // Core bus sample
  output logic                    match_b    // Comparator B match
);

  //--------------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------------
  // Storage; every flop clears on the asynchronous reset
  logic [7:0]  ext_b;      // comparator_b_extension
  logic [7:0]  ext_a;      // Comparator A extension (dir bits used)
  logic [16:0] cmp_adr;    // Comparator B address / data value
  logic [2:0]  ctrl;       // full, debug enable, begin
  logic        access_q;

  //--------------------------------------------------------------------------
  // APB decode
  //--------------------------------------------------------------------------
  // Zero wait states: the answer is registered from setup
  wire setup    = psel && !penable;
  wire acc      = psel && penable && access_q;
  wire wr       = acc && pwrite;
  wire hit_b    = (paddr == dcbq_pkg::CMP_B_EXT_ADDR);
  wire hit_a    = (paddr == dcbq_pkg::CMP_A_EXT_ADDR);
  wire hit_adr  = (paddr == dcbq_pkg::CMP_B_ADR_ADDR);
  wire hit_ctl  = (paddr == dcbq_pkg::CTRL_ADDR);
  wire hit_st   = (paddr == dcbq_pkg::STATUS_ADDR);
  wire mapped   = hit_b || hit_a || hit_adr || hit_ctl || hit_st;
  wire full_mode = ctrl[dcbq_pkg::CTRL_FULL];
  wire keep_ext = ctrl[dcbq_pkg::CTRL_DBG_EN] &&
                  !ctrl[dcbq_pkg::CTRL_BEGIN];

  // Read mux: if/else-if style chain as continuous selects
  wire [31:0] rd_val =
    hit_b   ? {24'h000000, ext_b & dcbq_pkg::EXT_RD_MASK} :
    hit_a   ? {24'h000000, ext_a & dcbq_pkg::EXT_RD_MASK} :
    hit_adr ? {15'h0000, cmp_adr} :
    hit_ctl ? {29'h00000000, ctrl} :
    hit_st  ? {31'h00000000, match_b} : 32'h00000000;

  //--------------------------------------------------------------------------
  // Match logic
  //--------------------------------------------------------------------------
  // direction enable select
  // full mode takes comparator A bits
  wire dir_en  = full_mode ? ext_a[dcbq_pkg::BIT_DIR_EN]
                           : ext_b[dcbq_pkg::BIT_DIR_EN];
  wire dir_val = full_mode ? ext_a[dcbq_pkg::BIT_DIR_VAL]
                           : ext_b[dcbq_pkg::BIT_DIR_VAL];
  wire dir_ok  = !dir_en || (core_bus.read == dir_val);
  wire pg_sel  = ext_b[dcbq_pkg::BIT_PAGE];
  wire pg_ok   = (core_bus.paged == pg_sel);
  wire [16:0] cmp_addr = core_bus.paged ?
                 {core_bus.page, core_bus.addr[13:0]} : core_bus.addr;
  wire b16_ok  = (cmp_addr[16] == ext_b[dcbq_pkg::BIT_B16]);
  wire adr_ok  = (cmp_addr[15:0] == cmp_adr[15:0]);
  wire dat_ok  = (core_bus.data == cmp_adr[7:0]);
  wire next_match = core_bus.valid && dir_ok &&
                    (full_mode ? dat_ok : (pg_ok && b16_ok && adr_ok));
  // Registered below, so the match trails its bus sample by one edge

  //--------------------------------------------------------------------------
  // Register process
  //--------------------------------------------------------------------------
  // End-trace wins over a register write in the same cycle
  // reset clears, end-trace keeps selected bits when debug enable is set and begin is clear, else clears
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ext_b <= dcbq_pkg::EXT_RESET;
      ext_a <= dcbq_pkg::EXT_RESET;
    end else if (end_trace_rst) begin
      ext_b <= keep_ext ? (ext_b & dcbq_pkg::EXT_KEEP_MASK)
                        : dcbq_pkg::EXT_RESET;
      ext_a <= keep_ext ? (ext_a & dcbq_pkg::EXT_KEEP_MASK)
                        : dcbq_pkg::EXT_RESET;
    end else begin
      if (wr && hit_b)
        ext_b <= pwdata[7:0] & dcbq_pkg::EXT_RD_MASK;
      if (wr && hit_a)
        ext_a <= pwdata[7:0] & dcbq_pkg::EXT_RD_MASK;
    end
  end

  // Other control registers and APB answer
  // pslverr rides with pready; writes to unmapped offsets drop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmp_adr  <= 17'h00000;
      ctrl     <= 3'h0;
      access_q <= 1'b0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h00000000;
      match_b  <= 1'b0;
    end else begin
      access_q <= setup;
      pready   <= setup;
      pslverr  <= setup && !mapped;
      prdata   <= (setup && !pwrite) ? rd_val : 32'h00000000;
      match_b  <= next_match;
      if (wr && hit_adr)
        cmp_adr <= pwdata[16:0];
      if (wr && hit_ctl)
        ctrl <= pwdata[2:0];
    end
  end

  //--------------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------------
  property p_dir_write;
    @(posedge clk_sys) disable iff (!nrst)
    (!full_mode && ext_b[7] && !ext_b[6] && core_bus.read) |=> !match_b;
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("write-only match fired on read");

  property p_dir_off;
    @(posedge clk_sys) disable iff (!nrst)
    (!full_mode && !ext_b[7] && core_bus.valid && pg_ok && b16_ok &&
     adr_ok) |=> match_b;
  endproperty
  a_dir_off: assert property (p_dir_off)
    else $error("direction not ignored when disabled");

  property p_page;
    @(posedge clk_sys) disable iff (!nrst)
    (!full_mode && core_bus.paged != ext_b[5]) |=> !match_b;
  endproperty
  a_page: assert property (p_page)
    else $error("page qualification violated");

  property p_b16;
    @(posedge clk_sys) disable iff (!nrst)
    (!full_mode && cmp_addr[16] != ext_b[0]) |=> !match_b;
  endproperty
  a_b16: assert property (p_b16)
    else $error("bit 16 mismatch produced match");

  property p_full_a;
    @(posedge clk_sys) disable iff (!nrst)
    (full_mode && ext_a[7] && core_bus.read != ext_a[6]) |=> !match_b;
  endproperty
  a_full_a: assert property (p_full_a)
    else $error("full mode ignored comparator A direction");

  property p_full_data;
    @(posedge clk_sys) disable iff (!nrst)
    (full_mode && !ext_a[7] && core_bus.valid && dat_ok) |=> match_b;
  endproperty
  a_full_data: assert property (p_full_data)
    else $error("full mode data match missed");

  property p_keep;
    @(posedge clk_sys) disable iff (!nrst)
    (end_trace_rst && keep_ext) |=>
      (ext_b == ($past(ext_b) & dcbq_pkg::EXT_KEEP_MASK));
  endproperty
  a_keep: assert property (p_keep)
    else $error("end-trace reset lost kept bits");

  property p_rsv;
    @(posedge clk_sys) disable iff (!nrst)
    (ext_b[4:1] == 4'h0);
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits nonzero");

  property p_dir_en;
    @(posedge clk_sys) disable iff (!nrst)
    (!full_mode && ext_b[7] && ext_b[6] && !core_bus.read) |=> !match_b;
  endproperty
  a_dir_en: assert property (p_dir_en)
    else $error("direction enable ignored");

  property p_full_val;
    @(posedge clk_sys) disable iff (!nrst)
    (full_mode && !ext_a[7] && ext_b[7] && core_bus.valid && dat_ok)
      |=> match_b;
  endproperty
  a_full_val: assert property (p_full_val)
    else $error("full mode used comparator B direction");

  property p_ready;
    @(posedge clk_sys) disable iff (!nrst)
    (psel && !penable) |=> pready;
  endproperty
  a_ready: assert property (p_ready) // Bus answer
    else $error("APB answer not one cycle");

  //--------------------------------------------------------------------------
  // Further qualifier and bus checks
  //--------------------------------------------------------------------------
  property p_dir_rd;
    @(posedge clk_sys) disable iff (!nrst)
    (!full_mode && ext_b[7] && ext_b[6] && core_bus.read &&
     core_bus.valid && pg_ok && b16_ok && adr_ok) |=> match_b;
  endproperty
  a_dir_rd: assert property (p_dir_rd)
    else $error("read-only match missed a read");

  property p_page_hit;
    @(posedge clk_sys) disable iff (!nrst)
    (!full_mode && !ext_b[7] && core_bus.valid && core_bus.paged &&
     ext_b[5] && {core_bus.page, core_bus.addr[13:0]} ==
     {ext_b[0], cmp_adr[15:0]}) |=> match_b;
  endproperty
  a_page_hit: assert property (p_page_hit)
    else $error("paged address match missed");

  property p_flat_hit;
    @(posedge clk_sys) disable iff (!nrst)
    (!full_mode && !ext_b[7] && core_bus.valid && !core_bus.paged &&
     !ext_b[5] && core_bus.addr == {ext_b[0], cmp_adr[15:0]})
      |=> match_b;
  endproperty
  a_flat_hit: assert property (p_flat_hit)
    else $error("unpaged address match missed");

  property p_full_ign;
    @(posedge clk_sys) disable iff (!nrst)
    (full_mode && !ext_a[7] && core_bus.valid &&
     core_bus.data == cmp_adr[7:0] && core_bus.paged != ext_b[5])
      |=> match_b;
  endproperty
  a_full_ign: assert property (p_full_ign)
    else $error("full mode used the page bit");

  property p_full_wr;
    @(posedge clk_sys) disable iff (!nrst)
    (full_mode && ext_a[7] && !ext_a[6] && !core_bus.read &&
     core_bus.valid && core_bus.data == cmp_adr[7:0]) |=> match_b;
  endproperty
  a_full_wr: assert property (p_full_wr)
    else $error("full mode write match missed");

  property p_clear;
    @(posedge clk_sys) disable iff (!nrst)
    (end_trace_rst && !keep_ext) |=> (ext_b == dcbq_pkg::EXT_RESET);
  endproperty
  a_clear: assert property (p_clear)
    else $error("end-trace reset kept bits without debug enable");

  property p_idle;
    @(posedge clk_sys) disable iff (!nrst)
    !core_bus.valid |=> !match_b;
  endproperty
  a_idle: assert property (p_idle)
    else $error("match without a bus cycle");

  property p_rd_b;
    @(posedge clk_sys) disable iff (!nrst)
    (psel && !penable && !pwrite && hit_b) |=>
      (prdata[31:8] == 24'h000000 && prdata[4:1] == 4'h0);
  endproperty
  a_rd_b: assert property (p_rd_b)
    else $error("unused extension bits read nonzero");

  property p_slverr;
    @(posedge clk_sys) disable iff (!nrst)
    (psel && !penable && !mapped) |=> (pready && pslverr);
  endproperty
  a_slverr: assert property (p_slverr) // Bus error
    else $error("unmapped access not flagged");

  property p_one_cycle;
    @(posedge clk_sys) disable iff (!nrst)
    pready |=> !pready;
  endproperty
  a_one_cycle: assert property (p_one_cycle) // Bus answer
    else $error("ready held beyond one cycle");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (!nrst)
    !pready |-> (prdata == 32'h00000000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) // Bus answer
    else $error("read data outside the access cycle");

  // Coverage of the main scenarios
  c_match:  cover property (@(posedge clk_sys) disable iff (!nrst) match_b);
  c_full:   cover property (@(posedge clk_sys) disable iff (!nrst)
                            full_mode && match_b);
  c_paged:  cover property (@(posedge clk_sys) disable iff (!nrst)
                            core_bus.paged && match_b);
  c_keep:   cover property (@(posedge clk_sys) disable iff (!nrst)
                            end_trace_rst && keep_ext);

endmodule

// File: dcbq_core_model.sv
// Core bus model that presents one bus sample per clock
`timescale 1ns/100ps
module dcbq_core_model (
  input  wire logic           clk_sys,  // Bus clock
  output dcbq_pkg::dcbq_bus_t core_bus  // Sample to the block
);
  initial core_bus = '0;
  // whole bus sample, launched just after an edge
  task automatic drive(input dcbq_pkg::dcbq_bus_t b);
    core_bus <= b;
    @(posedge clk_sys);
  endtask
  // Released bus shows the inverse, so stale fields never look valid
  task automatic idle();
    core_bus <= {1'b0, ~core_bus[29:0]};
  endtask
endmodule

// File: dcbq_top_tb.sv
// Self-checking bench for the comparator B qualifier
`timescale 1ns/100ps
module dcbq_top_tb;
  localparam logic [11:0] XB = dcbq_pkg::CMP_B_EXT_ADDR;
  localparam logic [11:0] XA = dcbq_pkg::CMP_A_EXT_ADDR;
  localparam logic [11:0] CV = dcbq_pkg::CMP_B_ADR_ADDR;
  localparam logic [11:0] CT = dcbq_pkg::CTRL_ADDR;
  logic                clk_sys = 1'b0;
  logic                nrst = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                match_b;
  logic                end_trace_rst = 1'b0;
  dcbq_pkg::dcbq_bus_t core_bus;
  dcbq_pkg::dcbq_bus_t b;
  int                  err_count = 0;
  int                  n_checks = 0;
  int                  seed = 20;
  logic [33:0]         rd_q[$];
  logic                mt_q[$];
  logic [33:0]         re;
  logic                m_due = 1'b0;
  logic [31:0]         r;
  logic [7:0]          eb, ea, ctrl;
  logic [16:0]         cv;

  always #5 clk_sys = ~clk_sys;

  dcbq_top u_dcbq_top (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .end_trace_rst(end_trace_rst), .core_bus(core_bus), .match_b(match_b));
  dcbq_core_model u_dcbq_core_model (.clk_sys(clk_sys), .core_bus(core_bus));

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One APB transfer; the expected answer is queued for the monitor
  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d,
                     input logic er, logic [31:0] e);
    int n;
    rd_q.push_back({w, er, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!pready && n < 16);
    if (!pready) begin
      err_count++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Reference match from the register mirror
  function automatic logic exp_match(dcbq_pkg::dcbq_bus_t x);
    logic [16:0] ca;
    ca = x.paged ? {x.page, x.addr[13:0]} : x.addr;
    if (ctrl[0]) return x.data == cv[7:0] && (!ea[7] || x.read == ea[6]);
    return x.paged == eb[5] && ca[15:0] == cv[15:0] && ca[16] == eb[0]
      && (!eb[7] || x.read == eb[6]);
  endfunction

  // Monitor: oldest note is compared as each result appears
  always @(posedge clk_sys) begin
    if (psel && penable && pready) begin
      re = rd_q.pop_front();
      chk("pslverr", {31'h0, re[32]}, {31'h0, pslverr});
      if (!re[33]) chk("prdata", re[31:0], prdata);
    end
    if (m_due)
      chk("match_b", {31'h0, mt_q.pop_front()}, {31'h0, match_b});
    m_due = nrst && core_bus.valid;
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, XB, 32'h0, 1'b0, 32'h0);
    apb(1'b1, 12'hFFC, 32'hFFFFFFFF, 1'b1, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0, 1'b1, 32'h0);
    apb(1'b1, XB, 32'hFFFFFFFF, 1'b0, 32'h0);
    apb(1'b0, XB, 32'h0, 1'b0, 32'hE1);
    $display("test registers done, %0d checks", n_checks);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      {eb, ea, cv[7:0], ctrl} = r;
      cv[16:8] = 9'($random(seed));
      ctrl = {6'h00, 1'b1, ctrl[0]};
      apb(1'b1, XB, {24'h0, eb}, 1'b0, 32'h0);
      apb(1'b1, XA, {24'h0, ea}, 1'b0, 32'h0);
      apb(1'b1, CV, {15'h0, cv}, 1'b0, 32'h0);
      apb(1'b1, CT, {24'h0, ctrl}, 1'b0, 32'h0);
      apb(1'b0, XB, 32'h0, 1'b0, {24'h0, eb & 8'hE1});
      apb(1'b0, XA, 32'h0, 1'b0, {24'h0, ea & 8'hE1});
      apb(1'b0, CV, 32'h0, 1'b0, {15'h0, cv});
      for (int j = 0; j < 8; j++) begin
        r = $random(seed);
        b = 31'($random(seed));
        b.valid = 1'b1;
        if (r[1:0] != 2'h0) begin
          b.paged = eb[5] ^ (ctrl[0] & r[3]); // flipped only in full mode, where the page bit is ignored
          b.addr = {eb[0], cv[15:0]};
          b.page = {eb[0], cv[15:14]};
          b.data = cv[7:0];
        end
        if (r[2]) b.read = ctrl[0] ? ea[6] : eb[6];
        mt_q.push_back(exp_match(b));
        u_dcbq_core_model.drive(b);
      end
      u_dcbq_core_model.idle();
    end
    $display("test match done, %0d checks", n_checks);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, CT, {29'h0, k[1], k[0], 1'b0}, 1'b0, 32'h0);
      apb(1'b1, XB, 32'h000000FF, 1'b0, 32'h0);
      end_trace_rst <= 1'b1;
      @(posedge clk_sys);
      end_trace_rst <= 1'b0;
      apb(1'b0, XB, 32'h0, 1'b0, (k == 1) ? 32'hE1 : 32'h0);
    end
    $display("test end-trace done, %0d checks", n_checks);
    apb(1'b1, XB, 32'h000000FF, 1'b0, 32'h0);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, XB, 32'h0, 1'b0, 32'h0);
    $display("test second reset done, %0d checks", n_checks);
    final_report();
  end
endmodule
